//--- mac_pkg.sv
package mac_pkg;

  // ----------------------------------------------------------------
  // Datapath constants
  // ----------------------------------------------------------------
  // Width of every operand and of the result.
  localparam int unsigned DATA_W = 32;
  // Register index that selects the program counter.
  localparam logic [3:0] PC_REG_IDX = 4'hf;
  // Bits of the combined status word that hold the address field.
  localparam logic [31:0] PC_FIELD_MASK = 32'h03fffffc;
  // Address advance seen by each operand slot when it names the PC.
  localparam logic [31:0] MCAND_PC_OFFSET = 32'h0000000c;
  localparam logic [31:0] MPLIER_PC_OFFSET = 32'h00000008;
  localparam logic [31:0] ADDEND_PC_OFFSET = 32'h00000008;
  // Position of the overflow flag inside the status word.
  localparam int unsigned PSW_V_BIT = 28;
  // Worst case number of Booth steps, two multiplier bits per step.
  localparam logic [4:0] WORST_STEPS = 5'h10;

  // ----------------------------------------------------------------
  // Register map of the AXI4-Lite window
  // ----------------------------------------------------------------
  localparam logic [11:0] CTRL_OFF = 12'h000;
  localparam logic [11:0] STATUS_OFF = 12'h004;
  localparam logic [11:0] COUNT_OFF = 12'h008;
  // Control: writing one clears the completion counter.
  localparam int unsigned CTRL_CLR_BIT = 0;
  // Status: busy, step count of the last operation, last N and Z.
  localparam int unsigned STATUS_BUSY_BIT = 0;
  localparam int unsigned STATUS_STEPS_LSB = 8;
  localparam int unsigned STATUS_N_BIT = 16;
  localparam int unsigned STATUS_Z_BIT = 17;
  // Reset values.
  localparam logic [31:0] COUNT_RESET = 32'h00000000;
  localparam logic [4:0] STEPS_RESET = 5'h00;
  // AXI response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_RUN = 1'b1
  } mac_state_type;

  // One issued instruction with its operand values.
  typedef struct packed {
    logic accumulate;
    logic set_flags;
    logic [3:0] dest_reg;
    logic [3:0] multiplicand_reg;
    logic [3:0] multiplier_reg;
    logic [3:0] addend_reg;
    logic [31:0] mcand_val;
    logic [31:0] mplier_val;
    logic [31:0] addend_val;
    logic [31:0] instr_addr;
    logic [31:0] processor_status_word;
  } issue_req_type;

  // One write back to the register file and the flags.
  typedef struct packed {
    logic [3:0] dest_reg;
    logic [31:0] value;
    logic flag_we;
    logic [3:0] nzcv;
  } wb_type;

endpackage

//--- multiply_accumulate_unit.sv
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// RULE1: Multiply operands, keep low 32 bits.
// RULE2: Accumulate form adds addend modulo two-to-32.
// RULE3: Radix-4 Booth, at most 16 cycles.
// RULE4: Stop early when remaining multiplier bits clear.
// RULE5: Low result correct for signed or unsigned.
// RULE6: Byte values treated as full words.
// RULE7: Flags change only with set-flags bit.
// RULE8: N,Z from result, C scrambled, V kept.
// RULE9: Issuer never names destination as multiplicand.
// RULE10: Issuer never writes the program counter.
// RULE11: PC multiplicand: flags included, plus 12.
// RULE12: PC multiplier: flags stripped, plus 8.
// RULE13: PC addend: flags included, plus 8.
// RULE14: Sixteen-bit operands finish within 8 cycles.
// RULE15: Busy stalls issue; single write when done.
module multiply_accumulate_unit
  import mac_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // Issue side from decode and register file.
  input wire logic issue_valid,
  input wire issue_req_type issue_req,
  output logic busy,
  // Write back side.
  output logic wb_valid,
  output wb_type wb,
  // AXI4-Lite write address and data.
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels.
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ----------------------------------------------------------------
  // Reset synchroniser
  // ----------------------------------------------------------------
  logic rst_meta_r; // First stage, read only by the second.
  logic rst_sync_r; // Synchronised active-high run enable.

  // Release the reset through two flops; assert it at once.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // Operand selection
  // ----------------------------------------------------------------
  wire [31:0] pc_psw_word; // Status bits of the combined PC word.
  wire [31:0] mcand_pc; // PC value as multiplicand.
  wire [31:0] mplier_pc; // PC value as multiplier.
  wire [31:0] addend_pc; // PC value as addend.
  wire [31:0] sel_mcand; // Chosen multiplicand.
  wire [31:0] sel_mplier; // Chosen multiplier.
  wire [31:0] sel_addend; // Chosen addend, zero for plain multiply.
  wire issue_take; // Instruction accepted this cycle.

  assign pc_psw_word = issue_req.processor_status_word & ~PC_FIELD_MASK;
  // RULE11 flags plus twelve.
  assign mcand_pc = ((issue_req.instr_addr + MCAND_PC_OFFSET) & PC_FIELD_MASK) | pc_psw_word;
  // RULE12 flags stripped, plus eight.
  assign mplier_pc = (issue_req.instr_addr + MPLIER_PC_OFFSET) & PC_FIELD_MASK;
  // RULE13 flags plus eight.
  assign addend_pc = ((issue_req.instr_addr + ADDEND_PC_OFFSET) & PC_FIELD_MASK) | pc_psw_word;
  assign sel_mcand = (issue_req.multiplicand_reg == PC_REG_IDX) ? mcand_pc : issue_req.mcand_val;
  assign sel_mplier = (issue_req.multiplier_reg == PC_REG_IDX) ? mplier_pc : issue_req.mplier_val;
  // RULE2 addend only in accumulate form.
  assign sel_addend = !issue_req.accumulate ? 32'h00000000 :
                      (issue_req.addend_reg == PC_REG_IDX) ? addend_pc : issue_req.addend_val;
  // RULE15 no issue while busy.
  assign issue_take = issue_valid && !busy;

  // ----------------------------------------------------------------
  // Booth step datapath
  // ----------------------------------------------------------------
  mac_state_type state_r; // Sequencer state.
  logic [31:0] acc_r; // Running sum of Booth terms.
  logic [31:0] mcand_sh_r; // Multiplicand shifted to the current digit.
  logic [31:0] rem_r; // Multiplier bits still to be consumed.
  logic prev_r; // Booth carry, the top bit of the last pair.
  logic [4:0] steps_r; // Steps done in the current operation.
  logic acc_mode_r; // Captured accumulate form.
  logic set_flags_r; // Captured set-flags bit.
  logic v_keep_r; // Overflow flag to be preserved.
  logic [3:0] dest_r; // Destination register index.
  wire [2:0] booth_sel; // Current radix-4 Booth window.
  wire [31:0] booth_term; // Term added in this step.
  wire [31:0] acc_step; // Sum after this step.
  wire [31:0] rem_next; // Remaining multiplier after this step.
  wire [31:0] tail_term; // Pending carry folded in on exit.
  wire [31:0] final_sum; // Result when this step is the last.
  wire finish; // This step completes the operation.
  wire [4:0] steps_next; // Step count including this step.

  assign booth_sel = {rem_r[1:0], prev_r};
  // RULE3 radix-4 Booth digit.
  assign booth_term = (booth_sel == 3'h1 || booth_sel == 3'h2) ? mcand_sh_r :
                      (booth_sel == 3'h3) ? {mcand_sh_r[30:0], 1'b0} :
                      (booth_sel == 3'h4) ? -{mcand_sh_r[30:0], 1'b0} :
                      (booth_sel == 3'h5 || booth_sel == 3'h6) ? -mcand_sh_r :
                      32'h00000000;
  assign acc_step = acc_r + booth_term;
  assign rem_next = {2'h0, rem_r[31:2]};
  // A pending carry is worth one multiplicand at the next digit.
  assign tail_term = rem_r[1] ? {mcand_sh_r[29:0], 2'h0} : 32'h00000000;
  // RULE1 low word kept; RULE5 modular sum fits either sign.
  assign final_sum = acc_step + tail_term;
  // RULE4 RULE14 exit once no multiplier bits remain.
  assign finish = (state_r == ST_RUN) && (rem_next == 32'h00000000);
  assign steps_next = steps_r + 5'h01;

  // Sequencer and working registers.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      acc_r <= 32'h00000000;
      mcand_sh_r <= 32'h00000000;
      rem_r <= 32'h00000000;
      prev_r <= 1'b0;
      steps_r <= STEPS_RESET;
    end else if (!rst_sync_r) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        // RULE6 full-word operands; byte values arrive as full words.
        ST_IDLE: begin
          if (issue_take) begin
            state_r <= ST_RUN;
            acc_r <= sel_addend;
            mcand_sh_r <= sel_mcand;
            rem_r <= sel_mplier;
            prev_r <= 1'b0;
            steps_r <= STEPS_RESET;
          end
        end
        // One Booth digit per clock.
        ST_RUN: begin
          acc_r <= acc_step;
          mcand_sh_r <= {mcand_sh_r[29:0], 2'h0};
          rem_r <= rem_next;
          prev_r <= rem_r[1];
          steps_r <= steps_next;
          if (finish) begin
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Instruction attributes held for the write back.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_mode_r <= 1'b0;
      set_flags_r <= 1'b0;
      v_keep_r <= 1'b0;
      dest_r <= 4'h0;
    end else if (issue_take) begin
      acc_mode_r <= issue_req.accumulate;
      set_flags_r <= issue_req.set_flags;
      v_keep_r <= issue_req.processor_status_word[PSW_V_BIT];
      dest_r <= issue_req.dest_reg;
    end
  end

  // ----------------------------------------------------------------
  // Busy and write back
  // ----------------------------------------------------------------
  logic [4:0] last_steps_r; // Step count of the last operation.
  logic [31:0] done_count_r; // Completed operations.
  wire clr_count; // Software clears the counter.

  // RULE15 busy from issue until the final step.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
    end else if (!rst_sync_r) begin
      busy <= 1'b0;
    end else begin
      busy <= issue_take || (busy && !finish);
    end
  end

  // Present the result once, as a single-cycle pulse.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_valid <= 1'b0;
      wb <= '0;
      last_steps_r <= STEPS_RESET;
    end else begin
      // RULE15 single write back.
      wb_valid <= finish;
      if (finish) begin
        wb.dest_reg <= dest_r;
        wb.value <= final_sum;
        // RULE7 flags written only on request.
        wb.flag_we <= set_flags_r;
        // RULE8 N and Z from result, carry scrambled, V kept.
        wb.nzcv <= {final_sum[31], final_sum == 32'h00000000, prev_r, v_keep_r};
        last_steps_r <= steps_next;
      end
    end
  end

  // Completion counter; a completion in the same cycle as a clear is counted after the clear, giving one.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_count_r <= COUNT_RESET;
    end else if (finish) begin
      done_count_r <= clr_count ? 32'h00000001 : done_count_r + 32'h00000001;
    end else if (clr_count) begin
      done_count_r <= COUNT_RESET;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic aw_full_r; // Write address held.
  logic w_full_r; // Write data held.
  logic [11:0] aw_addr_r; // Held write address.
  logic [31:0] w_data_r; // Held write data.
  logic [3:0] w_strb_r; // Held byte strobes.
  wire aw_take; // Address handshake.
  wire w_take; // Data handshake.
  wire wr_do; // Perform the held write.
  wire aw_full_nxt; // Next address-held state.
  wire w_full_nxt; // Next data-held state.
  wire bvalid_nxt; // Next write response valid.
  wire ar_take; // Read address handshake.
  wire rvalid_nxt; // Next read data valid.
  wire wr_mapped; // Held write hits the control register.
  wire rd_mapped; // Read address hits a register.
  wire [31:0] status_word; // Assembled status register.
  wire [31:0] rd_word; // Selected read data.

  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign wr_do = aw_full_r && w_full_r && !s_axi_bvalid;
  assign aw_full_nxt = (aw_full_r && !wr_do) || aw_take;
  assign w_full_nxt = (w_full_r && !wr_do) || w_take;
  assign bvalid_nxt = (s_axi_bvalid && !s_axi_bready) || wr_do;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign rvalid_nxt = (s_axi_rvalid && !s_axi_rready) || ar_take;
  assign wr_mapped = (aw_addr_r == CTRL_OFF);
  assign clr_count = wr_do && wr_mapped && w_strb_r[0] && w_data_r[CTRL_CLR_BIT];
  assign rd_mapped = (s_axi_araddr == CTRL_OFF) || (s_axi_araddr == STATUS_OFF) ||
                     (s_axi_araddr == COUNT_OFF);
  assign status_word = (32'(busy) << STATUS_BUSY_BIT) |
                       (32'(last_steps_r) << STATUS_STEPS_LSB) |
                       (32'(wb.nzcv[3]) << STATUS_N_BIT) |
                       (32'(wb.nzcv[2]) << STATUS_Z_BIT);
  assign rd_word = (s_axi_araddr == STATUS_OFF) ? status_word :
                   (s_axi_araddr == COUNT_OFF) ? done_count_r : 32'h00000000;

  // Write channels: address and data are latched in either order.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      aw_addr_r <= 12'h000;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (!rst_sync_r) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      aw_full_r <= aw_full_nxt;
      w_full_r <= w_full_nxt;
      if (aw_take) begin
        aw_addr_r <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      s_axi_awready <= !aw_full_nxt && !bvalid_nxt;
      s_axi_wready <= !w_full_nxt && !bvalid_nxt;
      s_axi_bvalid <= bvalid_nxt;
      if (wr_do) begin
        s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Read channels: one read at a time, answered the cycle after.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else if (!rst_sync_r) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !rvalid_nxt;
      s_axi_rvalid <= rvalid_nxt;
      if (ar_take) begin
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic [31:0] exp_value_r; // Reference result of the issued operation.
  logic exp_flags_r; // Reference set-flags bit.

  // Reference model sampled at issue.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      exp_value_r <= 32'h00000000;
      exp_flags_r <= 1'b0;
    end else if (issue_take) begin
      exp_value_r <= sel_mcand * sel_mplier + sel_addend;
      exp_flags_r <= issue_req.set_flags;
    end
  end

  property p_result_value;
    @(posedge sys_clk) disable iff (!rst_sync_r)
    wb_valid |-> wb.value == exp_value_r;
  endproperty
  a_result_value: assert property (p_result_value) else $error("wrong result"); // RULE1 RULE2 RULE5

  property p_worst_case;
    @(posedge sys_clk) disable iff (!rst_sync_r)
    issue_take |-> ##[2:17] wb_valid;
  endproperty
  a_worst_case: assert property (p_worst_case) else $error("too slow"); // RULE3

  property p_early_exit;
    @(posedge sys_clk) disable iff (!rst_sync_r)
    issue_take && sel_mplier[31:8] == 24'h000000 |-> ##[2:5] wb_valid;
  endproperty
  a_early_exit: assert property (p_early_exit) else $error("no early exit"); // RULE4

  property p_half_word;
    @(posedge sys_clk) disable iff (!rst_sync_r)
    issue_take && sel_mplier[31:16] == 16'h0000 |-> ##[2:9] wb_valid;
  endproperty
  a_half_word: assert property (p_half_word) else $error("half-word too slow"); // RULE14

  property p_flag_gate;
    @(posedge sys_clk) disable iff (!rst_sync_r)
    wb_valid |-> wb.flag_we == exp_flags_r;
  endproperty
  a_flag_gate: assert property (p_flag_gate) else $error("flag write wrong"); // RULE7

  property p_flag_value;
    @(posedge sys_clk) disable iff (!rst_sync_r)
    wb_valid && wb.flag_we |-> wb.nzcv[3] == wb.value[31] &&
      wb.nzcv[2] == (wb.value == 32'h00000000) && wb.nzcv[0] == v_keep_r;
  endproperty
  a_flag_value: assert property (p_flag_value) else $error("flag value wrong"); // RULE8

  property p_pc_mcand;
    @(posedge sys_clk) disable iff (!rst_sync_r)
    issue_take && issue_req.multiplicand_reg == PC_REG_IDX |=>
      mcand_sh_r == ($past(issue_req.instr_addr) + 32'h0000000c & PC_FIELD_MASK |
      $past(issue_req.processor_status_word) & ~PC_FIELD_MASK);
  endproperty
  a_pc_mcand: assert property (p_pc_mcand) else $error("pc multiplicand wrong"); // RULE11

  property p_pc_mplier;
    @(posedge sys_clk) disable iff (!rst_sync_r)
    issue_take && issue_req.multiplier_reg == PC_REG_IDX |=>
      rem_r == ($past(issue_req.instr_addr) + 32'h00000008 & PC_FIELD_MASK);
  endproperty
  a_pc_mplier: assert property (p_pc_mplier) else $error("pc multiplier wrong"); // RULE12

  property p_pc_addend;
    @(posedge sys_clk) disable iff (!rst_sync_r)
    issue_take && issue_req.accumulate && issue_req.addend_reg == PC_REG_IDX |=>
      acc_r == ($past(issue_req.instr_addr) + 32'h00000008 & PC_FIELD_MASK |
      $past(issue_req.processor_status_word) & ~PC_FIELD_MASK);
  endproperty
  a_pc_addend: assert property (p_pc_addend) else $error("pc addend wrong"); // RULE13

  property p_busy_write;
    @(posedge sys_clk) disable iff (!rst_sync_r)
    $fell(busy) |-> wb_valid ##1 !wb_valid;
  endproperty
  a_busy_write: assert property (p_busy_write) else $error("write back not single"); // RULE15

endmodule

`default_nettype wire

//--- mac_issuer.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Issue side model: decode and operand fetch.
// ----------------------------------------------------------------
module mac_issuer
  import mac_pkg::*;
(
  // Clock.
  input wire logic sys_clk,
  // Stall from the unit.
  input wire logic busy,
  // Issue to the unit.
  output logic issue_valid,
  output issue_req_type issue_req
);
  // Free running edge count, used to time each answer.
  int cyc = 0;
  initial issue_valid = 1'b0;
  initial issue_req = '0;
  // Count every rising edge.
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
  end
  // Offer one request and hold it until an idle edge takes it.
  task automatic issue(inout issue_req_type r, output int t);
    if (r.dest_reg == r.multiplicand_reg || r.dest_reg == PC_REG_IDX) begin
      r.dest_reg = (r.multiplicand_reg == 4'h0) ? 4'h1 : 4'h0;
    end
    issue_valid <= 1'b1;
    issue_req <= r;
    do @(posedge sys_clk); while (busy !== 1'b0);
    t = cyc;
  endtask
  // Stop offering once the stream is over.
  task automatic release_req();
    issue_valid <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- tb_multiply_accumulate_unit.sv
`timescale 1ns/1ps
`default_nettype none
module tb_multiply_accumulate_unit
  import mac_pkg::*;
();
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  typedef struct {
    logic [31:0] val;
    logic [3:0] dest;
    logic sf;
    logic v;
    int at;
  } note_type;
  note_type notes[$];
  note_type nt;
  int error_cnt = 0;
  int checks = 0;
  int ops = 0;
  int last_s = 0;
  logic [31:0] last_p = '0;
  logic [31:0] seed = 32'h48743f11;
  logic [31:0] v = '0;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic issue_valid, busy, wb_valid;
  issue_req_type issue_req;
  wb_type wb;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  // The clock toggles every half period of 5 ns.
  always #5 sys_clk = ~sys_clk;
  multiply_accumulate_unit DUT (.sys_clk(sys_clk), .rst_n(rst_n), .issue_valid(issue_valid),
    .issue_req(issue_req), .busy(busy), .wb_valid(wb_valid), .wb(wb),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  mac_issuer ISS (.sys_clk(sys_clk), .busy(busy), .issue_valid(issue_valid),
    .issue_req(issue_req));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Xorshift source of random operands.
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Operand value, with the PC word when index 15 is named, status bits included only when fl is set.
  function automatic logic [31:0] opnd(logic [3:0] i, logic [31:0] x, issue_req_type r,
                                       logic [31:0] off, logic fl);
    if (i != PC_REG_IDX) return x;
    return ((r.instr_addr + off) & PC_FIELD_MASK) |
           (fl ? (r.processor_status_word & ~PC_FIELD_MASK) : 32'h0);
  endfunction
  // Booth steps: two multiplier bits per step, at least one.
  function automatic int steps(logic [31:0] m);
    int s = 1;
    for (int i = 0; i < 16; i++) if (m[2*i +: 2] != 2'b00) s = i + 1;
    return s;
  endfunction
  // One comparison, counted, reported at once on a mismatch.
  task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  // Issue one operation and note its expected result.
  task automatic run_op(logic acc, logic sf, logic [3:0] mc, logic [3:0] mp, logic [3:0] ad,
                        logic [31:0] a, logic [31:0] b, logic [31:0] c);
    issue_req_type r;
    logic [31:0] y;
    int t;
    r = '{acc, sf, 4'(rnd()), mc, mp, ad, a, b, c, rnd(), rnd()};
    ISS.issue(r, t);
    y = opnd(mp, b, r, MPLIER_PC_OFFSET, 1'b0);
    last_p = opnd(mc, a, r, MCAND_PC_OFFSET, 1'b1) * y;
    if (acc) last_p = last_p + opnd(ad, c, r, ADDEND_PC_OFFSET, 1'b1);
    last_s = steps(y);
    notes.push_back(note_type'{last_p, r.dest_reg, sf, r.processor_status_word[PSW_V_BIT],
                      t + last_s + 1});
    ops++;
  endtask
  // AXI4-Lite write with the response code expected.
  task automatic wr(logic [11:0] a, logic [31:0] d, logic [1:0] e);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    cmp("bresp", 32'(e), 32'(s_axi_bresp));
  endtask
  // AXI4-Lite read, data compared under a mask.
  task automatic rd(logic [11:0] a, logic [31:0] e, logic [1:0] er, logic [31:0] m);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    cmp("rresp", 32'(er), 32'(s_axi_rresp));
    cmp("rdata", e & m, s_axi_rdata & m);
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Result monitor: each write back takes the oldest note.
  // ----------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (wb_valid === 1'b1) begin
      if (notes.size() == 0) cmp("extra_wb", 32'h0, 32'h1);
      else begin
        nt = notes.pop_front();
        cmp("value", nt.val, wb.value);
        cmp("dest", 32'(nt.dest), 32'(wb.dest_reg));
        cmp("flag_we", 32'(nt.sf), 32'(wb.flag_we));
        if (nt.sf) cmp("n_z", {nt.val[31], nt.val == 0}, 32'(wb.nzcv[3:2]));
        if (nt.sf) cmp("v", 32'(nt.v), 32'(wb.nzcv[0]));
        cmp("latency", nt.at, ISS.cyc);
        cmp("busy", 32'h0, 32'(busy));
      end
    end
  end
  // Watchdog far beyond the expected run length.
  initial begin
    #300000;
    error_cnt++;
    wrap_up();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge sys_clk);
    rd(COUNT_OFF, COUNT_RESET, RESP_OKAY, 32'hffffffff);
    rd(STATUS_OFF, {19'h0, STEPS_RESET, 8'h0}, RESP_OKAY, 32'h00001f01);
    run_op(0, 1, 1, 2, 3, 32'h7, 32'h6, 0);
    run_op(0, 1, 1, 2, 3, 32'h12345678, 32'hc0000000, 0);
    run_op(0, 1, 1, 2, 3, 32'h9, 32'h0, 0);
    run_op(0, 0, 1, 2, 3, 32'hffffffff, 32'h0000ffff, 0);
    run_op(0, 1, 1, 2, 3, 32'h0000ffff, 32'h0000ffff, 0);
    run_op(0, 1, 1, 2, 3, 32'hfffffffd, 32'hfffffffb, 0);
    run_op(0, 1, 1, 2, 3, 32'h000000ff, 32'h00000080, 0);
    run_op(1, 1, 1, 2, 3, 32'hffffffff, 32'h3, 32'h5);
    run_op(1, 1, 4'hf, 2, 3, 32'h0, 32'h5, 32'h1);
    run_op(0, 1, 1, 4'hf, 3, 32'h3, 32'h0, 0);
    run_op(1, 0, 1, 2, 4'hf, 32'h2, 32'h2, 32'h0);
    for (int i = 0; i < 24; i++) begin
      v = rnd();
      run_op(v[0], v[1], v[7:4], v[11:8], v[15:12], rnd(), rnd() >> v[20:16], rnd());
    end
    run_op(0, 1, 1, 2, 3, 32'h5, 32'h80000000, 0);
    ISS.release_req();
    rd(STATUS_OFF, 32'h1, RESP_OKAY, 32'h1);
    while (notes.size() != 0 || busy !== 1'b0) @(posedge sys_clk);
    $display("test operations done");
    rd(COUNT_OFF, ops, RESP_OKAY, 32'hffffffff);
    rd(STATUS_OFF, {14'h0, last_p == 0, last_p[31], 3'h0, 5'(last_s), 8'h0}, RESP_OKAY,
       32'h00031f01);
    s_axi_wstrb <= 4'he;
    wr(CTRL_OFF, 32'h1, RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    wr(12'h100, 32'h1, RESP_SLVERR);
    wr(COUNT_OFF, 32'h5, RESP_SLVERR);
    rd(COUNT_OFF, ops, RESP_OKAY, 32'hffffffff);
    wr(CTRL_OFF, 32'h1, RESP_OKAY);
    rd(COUNT_OFF, 32'h0, RESP_OKAY, 32'hffffffff);
    rd(CTRL_OFF, 32'h0, RESP_OKAY, 32'hffffffff);
    rd(12'h100, 32'h0, RESP_SLVERR, 32'hffffffff);
    wr(STATUS_OFF, 32'h5, RESP_SLVERR);
    rd(COUNT_OFF, 32'h0, RESP_OKAY, 32'hffffffff);
    $display("test registers done");
    wrap_up();
  end
endmodule
`default_nettype wire
